//--- inc/tcdp_pkg.sv
// Constants for the timer data port, prefetch latch and counter groups
package tcdp_pkg;
    localparam int N_CNT = 5;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Data pointer group codes
    localparam logic [2:0] GP_FIRST = 3'h1;
    localparam logic [2:0] GP_LAST = 3'h5;
    localparam logic [2:0] GP_BAD = 3'h6;
    localparam logic [2:0] GP_CTRL = 3'h7;
    localparam logic [2:0] GP_NONE = 3'h0;
    // Element codes in a counter group
    localparam logic [1:0] EL_MODE = 2'h0;
    localparam logic [1:0] EL_LOAD = 2'h1;
    localparam logic [1:0] EL_HOLD = 2'h2;
    localparam logic [1:0] EL_HOLDC = 2'h3;
    // Element codes in the control group
    localparam logic [1:0] CE_ALARM1 = 2'h0;
    localparam logic [1:0] CE_ALARM2 = 2'h1;
    localparam logic [1:0] CE_MASTER = 2'h2;
    localparam logic [1:0] CE_STATUS = 2'h3;
    // Command opcodes, bits 7..5
    localparam logic [2:0] OP_LDP = 3'h0;
    localparam logic [2:0] OP_ARM = 3'h1;
    localparam logic [2:0] OP_LOAD = 3'h2;
    localparam logic [2:0] OP_LDARM = 3'h3;
    localparam logic [2:0] OP_DISSAVE = 3'h4;
    localparam logic [2:0] OP_SAVE = 3'h5;
    localparam logic [2:0] OP_DISARM = 3'h6;
    localparam logic [2:0] OP_MISC = 3'h7;
    localparam logic [1:0] SUB_CLR = 2'h0;
    localparam logic [1:0] SUB_SET = 2'h1;
    localparam logic [1:0] SUB_STEP = 2'h2;
    localparam logic [7:0] CMD_MRESET = 8'hff;
    localparam logic [2:0] N_SEQ = 3'h0;
    localparam logic [2:0] N_FGATE = 3'h6;
    localparam logic [2:0] N_BUS = 3'h7;
    // Master mode bit positions and reset
    localparam int MM_CMP1 = 2;
    localparam int MM_CMP2 = 3;
    localparam int MM_FGATE = 12;
    localparam int MM_BUS16 = 13;
    localparam int MM_NOSEQ = 14;
    // Counter mode bit positions
    localparam int CM_UP = 4;
    localparam int CM_REPEAT = 5;
    localparam int CM_RSRC = 6;
    localparam int CM_SPGATE = 7;
    localparam logic [2:0] OC_LOWZ = 3'h0;
    localparam logic [2:0] OC_TOGGLE = 3'h2;
    localparam logic [2:0] OC_HIZ = 3'h4;
    localparam logic [2:0] OC_LOW = 3'h5;
    localparam logic [2:0] GATE_NONE = 3'h0;
    localparam logic [2:0] GATE_EDGE = 3'h6;
    localparam logic [15:0] TERM_DN = 16'h0001;
    localparam logic [15:0] TERM_UP = 16'hffff;
    // Status byte: bit 0 byte pointer, bits 1..5 counter outputs
    localparam int ST_BYTE = 0;
    localparam int ST_OUT_LSB = 1;
    typedef enum logic [1:0] {
        PF_IDLE = 2'b01,
        PF_FETCH = 2'b10
    } tcdp_pf_st_t;
endpackage

//--- inc/tcdp_grp_if.sv
// Signals between the data port logic and one counter group
`timescale 1ns/100ps
`default_nettype none
interface tcdp_grp_if;
    logic wr_mode, wr_load, wr_hold, wr_alarm;
    logic [1:0] wr_be;
    logic [15:0] wr_data;
    logic cmd_arm, cmd_disarm, cmd_load, cmd_save, cmd_step;
    logic cmd_set, cmd_clr, cmd_reset, cmp_en;
    logic [15:0] mode_q, load_q, hold_q, alarm_q;
    logic out_pin, out_oe_n, status_bit;
    modport ctl (output wr_mode, wr_load, wr_hold, wr_alarm, wr_be, wr_data,
        cmd_arm, cmd_disarm, cmd_load, cmd_save, cmd_step, cmd_set, cmd_clr,
        cmd_reset, cmp_en, input mode_q, load_q, hold_q, alarm_q, out_pin,
        out_oe_n, status_bit);
    modport grp (input wr_mode, wr_load, wr_hold, wr_alarm, wr_be, wr_data,
        cmd_arm, cmd_disarm, cmd_load, cmd_save, cmd_step, cmd_set, cmd_clr,
        cmd_reset, cmp_en, output mode_q, load_q, hold_q, alarm_q, out_pin,
        out_oe_n, status_bit);
endinterface
`default_nettype wire

//--- hw/tcdp_group.sv
// One counter group: counter, load, hold, mode, alarm and output logic
`timescale 1ns/100ps
`default_nettype none
module tcdp_group #(
    parameter bit HAS_ALARM = 1'b0
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic gate,
    tcdp_grp_if.grp g
);
    logic [15:0] count_q, count_d, load_q, load_d, hold_q, hold_d;
    logic [15:0] mode_q, mode_d, alarm_q, alarm_d, src, nxt;
    logic armed_q, armed_d, run_q, run_d, alt_q, alt_d;
    logic tc_q, tc_d, tog_q, tog_d, gate_q;
    logic [2:0] gctl, oc;
    logic up, rise, en, term, cmp, norm;

    // Byte-lane merge for host writes
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] be);
        merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    // Count, reload, capture and host access
    always_comb
    begin
        count_d = count_q; load_d = load_q; hold_d = hold_q;
        mode_d = mode_q; alarm_d = alarm_q; armed_d = armed_q;
        run_d = run_q; alt_d = alt_q; tc_d = tc_q; tog_d = tog_q;
        gctl = mode_q[15:13];
        up = mode_q[tcdp_pkg::CM_UP];
        rise = gate & ~gate_q;
        en = armed_q & ((gctl == tcdp_pkg::GATE_NONE) ||
             ((gctl == tcdp_pkg::GATE_EDGE) ? run_q : gate));
        src = (mode_q[tcdp_pkg::CM_RSRC] & alt_q) ? hold_q : load_q;
        term = up ? (count_q == tcdp_pkg::TERM_UP)
                  : (count_q == tcdp_pkg::TERM_DN);
        nxt = up ? count_q + 16'h0001 : count_q - 16'h0001;
        if (armed_q && gctl == tcdp_pkg::GATE_EDGE && rise)
            run_d = 1'b1;
        if (tick & en)
        begin
            tc_d = term;
            if (term)
            begin
                count_d = src;
                alt_d = mode_q[tcdp_pkg::CM_RSRC] & ~alt_q;
                tog_d = ~tog_q;
                // Alternating reload ends after the second terminal count
                if (~mode_q[tcdp_pkg::CM_RSRC] | alt_q)
                begin
                    run_d = 1'b0;
                    if (~mode_q[tcdp_pkg::CM_REPEAT])
                        armed_d = 1'b0;
                end
            end
            else
                count_d = nxt;
        end
        // Gate-edge save; the data port latch is left untouched
        if (mode_q[tcdp_pkg::CM_SPGATE] && ~mode_q[tcdp_pkg::CM_RSRC] &&
            gctl != tcdp_pkg::GATE_NONE && rise)
        begin
            hold_d = count_q;
            count_d = load_q;
        end
        if (g.cmd_load) count_d = src;
        if (g.cmd_step) count_d = nxt;
        if (g.cmd_save) hold_d = count_q;
        if (g.cmd_arm) armed_d = 1'b1;
        if (g.cmd_disarm) armed_d = 1'b0;
        if (g.cmd_set) tog_d = 1'b1;
        if (g.cmd_clr) tog_d = 1'b0;
        // Host writes; the counter itself has no address
        if (g.wr_mode) mode_d = merge(mode_q, g.wr_data, g.wr_be);
        if (g.wr_load) load_d = merge(load_q, g.wr_data, g.wr_be);
        if (g.wr_hold) hold_d = merge(hold_q, g.wr_data, g.wr_be);
        if (g.wr_alarm && HAS_ALARM)
            alarm_d = merge(alarm_q, g.wr_data, g.wr_be);
        if (g.cmd_reset)
        begin
            count_d = tcdp_pkg::REG_RESET; load_d = tcdp_pkg::REG_RESET;
            hold_d = tcdp_pkg::REG_RESET; mode_d = tcdp_pkg::REG_RESET;
            alarm_d = tcdp_pkg::REG_RESET; armed_d = 1'b0; run_d = 1'b0;
            alt_d = 1'b0; tc_d = 1'b0; tog_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q <= tcdp_pkg::REG_RESET; load_q <= tcdp_pkg::REG_RESET;
            hold_q <= tcdp_pkg::REG_RESET; mode_q <= tcdp_pkg::REG_RESET;
            alarm_q <= tcdp_pkg::REG_RESET; armed_q <= 1'b0; run_q <= 1'b0;
            alt_q <= 1'b0; tc_q <= 1'b0; tog_q <= 1'b0; gate_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d; load_q <= load_d; hold_q <= hold_d;
            mode_q <= mode_d; alarm_q <= alarm_d; armed_q <= armed_d;
            run_q <= run_d; alt_q <= alt_d; tc_q <= tc_d; tog_q <= tog_d;
            gate_q <= gate;
        end
    end

    // Output polarity; comparator holds true until the count moves
    always_comb
    begin
        oc = mode_q[2:0];
        cmp = g.cmp_en & HAS_ALARM & (count_q == alarm_q);
        unique case (oc)
            tcdp_pkg::OC_TOGGLE: norm = tog_q;
            tcdp_pkg::OC_LOW, tcdp_pkg::OC_HIZ: norm = ~tc_q;
            default: norm = tc_q;
        endcase
        g.out_pin = g.cmp_en ? (oc[2] ? ~cmp : cmp) : norm;
        g.status_bit = (g.cmp_en && oc == tcdp_pkg::OC_HIZ) ? cmp
                                                          : g.out_pin;
        g.out_oe_n = (oc == tcdp_pkg::OC_HIZ);
    end

    assign g.mode_q = mode_q;
    assign g.load_q = load_q;
    assign g.hold_q = hold_q;
    assign g.alarm_q = alarm_q;
endmodule // tcdp_group
`default_nettype wire

//--- hw/tcdp_top.sv
// Timer data port with prefetch latch, status byte and five counter groups
`timescale 1ns/100ps
`default_nettype none
module tcdp_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cd_sel,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [15:0] db_in,
    output logic [15:0] db_out,
    output logic db_oe_n,
    input wire logic [4:0] cnt_tick,
    input wire logic [4:0] gate_in,
    output logic [4:0] out_pin,
    output logic [4:0] out_oe_n
);
    localparam int NC = tcdp_pkg::N_CNT;

    tcdp_grp_if gi[NC] ();

    logic [2:0] grp_q, grp_d;
    logic [1:0] elem_q, elem_d;
    logic byte_q, byte_d;
    logic [15:0] mm_q, mm_d, pf_q, pf_d, word, wdata;
    tcdp_pkg::tcdp_pf_st_t pf_st_q, pf_st_d;
    logic [7:0] status_q, status_d, cmd;
    logic [1:0] be;
    logic bus16, data_acc, data_wr, cmd_wr, full, mreset;
    logic [2:0] n_fld;
    logic [15:0] mode_a [NC];
    logic [15:0] load_a [NC];
    logic [15:0] hold_a [NC];
    logic [15:0] alarm_a [NC];
    logic [NC-1:0] st_a, wr_mode_v, wr_load_v, wr_hold_v, wr_alarm_v;
    logic [NC-1:0] arm_v, disarm_v, load_v, save_v, step_v, set_v, clr_v;
    logic [NC-1:0] cmp_en_v;

    // Port decode: select line chooses command/status or data port
    always_comb
    begin
        bus16 = mm_q[tcdp_pkg::MM_BUS16];
        data_acc = ~cd_sel & (rd_stb | wr_stb);
        data_wr = ~cd_sel & wr_stb;
        cmd_wr = cd_sel & wr_stb;
        cmd = db_in[7:0];
        n_fld = cmd[2:0];
        mreset = cmd_wr && cmd == tcdp_pkg::CMD_MRESET;
        // Eight-bit mode writes one byte lane chosen by the byte pointer
        be = bus16 ? 2'h3 : (byte_q ? 2'h1 : 2'h2);
        wdata = bus16 ? db_in : {db_in[7:0], db_in[7:0]};
    end

    // Register selected by the data pointer
    always_comb
    begin
        word = 16'h0000;
        if (grp_q == tcdp_pkg::GP_CTRL)
        begin
            unique case (elem_q)
                tcdp_pkg::CE_ALARM1: word = alarm_a[0];
                tcdp_pkg::CE_ALARM2: word = alarm_a[1];
                tcdp_pkg::CE_MASTER: word = mm_q;
                tcdp_pkg::CE_STATUS: word = {8'h00, status_q};
            endcase
        end
        else
        begin
            for (int i = 0; i < NC; i++)
            begin
                if (grp_q == 3'(i + 1))
                begin
                    unique case (elem_q)
                        tcdp_pkg::EL_MODE: word = mode_a[i];
                        tcdp_pkg::EL_LOAD: word = load_a[i];
                        tcdp_pkg::EL_HOLD, tcdp_pkg::EL_HOLDC: word = hold_a[i];
                    endcase
                end
            end
        end
    end

    // Command and data write strobes toward the counter groups
    always_comb
    begin
        arm_v = '0; disarm_v = '0; load_v = '0; save_v = '0;
        step_v = '0; set_v = '0; clr_v = '0;
        wr_mode_v = '0; wr_load_v = '0; wr_hold_v = '0; wr_alarm_v = '0;
        if (cmd_wr)
        begin
            unique case (cmd[7:5])
                tcdp_pkg::OP_ARM: arm_v = cmd[4:0];
                tcdp_pkg::OP_LOAD: load_v = cmd[4:0];
                tcdp_pkg::OP_LDARM:
                begin
                    load_v = cmd[4:0];
                    arm_v = cmd[4:0];
                end
                tcdp_pkg::OP_DISSAVE:
                begin
                    disarm_v = cmd[4:0];
                    save_v = cmd[4:0];
                end
                tcdp_pkg::OP_SAVE: save_v = cmd[4:0];
                tcdp_pkg::OP_DISARM: disarm_v = cmd[4:0];
                tcdp_pkg::OP_MISC:
                begin
                    for (int i = 0; i < NC; i++)
                    begin
                        if (n_fld == 3'(i + 1))
                        begin
                            set_v[i] = (cmd[4:3] == tcdp_pkg::SUB_SET);
                            clr_v[i] = (cmd[4:3] == tcdp_pkg::SUB_CLR);
                            step_v[i] = (cmd[4:3] == tcdp_pkg::SUB_STEP);
                        end
                    end
                end
                default: ;
            endcase
        end
        if (data_wr)
        begin
            for (int i = 0; i < NC; i++)
            begin
                if (grp_q == 3'(i + 1))
                begin
                    wr_mode_v[i] = (elem_q == tcdp_pkg::EL_MODE);
                    wr_load_v[i] = (elem_q == tcdp_pkg::EL_LOAD);
                    wr_hold_v[i] = elem_q[1];
                end
            end
            if (grp_q == tcdp_pkg::GP_CTRL)
            begin
                wr_alarm_v[0] = (elem_q == tcdp_pkg::CE_ALARM1);
                wr_alarm_v[1] = (elem_q == tcdp_pkg::CE_ALARM2);
            end
        end
    end

    // Data pointer, master mode and prefetch latch: next values
    always_comb
    begin
        grp_d = grp_q; elem_d = elem_q; byte_d = byte_q;
        mm_d = mm_q; pf_d = pf_q; pf_st_d = tcdp_pkg::PF_IDLE;
        // Latch captures the register the pointer now names
        if (pf_st_q == tcdp_pkg::PF_FETCH)
            pf_d = bus16 ? word
                         : {8'h00, byte_q ? word[7:0] : word[15:8]};
        full = bus16 | ~byte_q;
        if (data_acc)
        begin
            byte_d = bus16 ? 1'b1 : ~byte_q;
            pf_st_d = tcdp_pkg::PF_FETCH;
            if (full && !mm_q[tcdp_pkg::MM_NOSEQ])
            begin
                if (grp_q == tcdp_pkg::GP_CTRL)
                begin
                    if (elem_q != tcdp_pkg::CE_STATUS)
                        elem_d = (elem_q == tcdp_pkg::CE_MASTER) ?
                                 tcdp_pkg::CE_ALARM1 : elem_q + 2'h1;
                end
                else if (elem_q == tcdp_pkg::EL_HOLDC ||
                         elem_q == tcdp_pkg::EL_HOLD)
                begin
                    // Hold cycle keeps element; element cycle wraps to mode
                    if (elem_q == tcdp_pkg::EL_HOLD)
                        elem_d = tcdp_pkg::EL_MODE;
                    grp_d = (grp_q == tcdp_pkg::GP_LAST) ? tcdp_pkg::GP_FIRST
                                                       : grp_q + 3'h1;
                end
                else
                    elem_d = elem_q + 2'h1;
            end
        end
        if (data_wr && grp_q == tcdp_pkg::GP_CTRL &&
            elem_q == tcdp_pkg::CE_MASTER)
        begin
            if (be[0]) mm_d[7:0] = wdata[7:0];
            if (be[1]) mm_d[15:8] = wdata[15:8];
        end
        if (cmd_wr && cmd[7:5] == tcdp_pkg::OP_LDP &&
            n_fld != tcdp_pkg::GP_NONE && n_fld != tcdp_pkg::GP_BAD)
        begin
            grp_d = n_fld;
            elem_d = cmd[4:3];
            byte_d = 1'b1;
            pf_st_d = tcdp_pkg::PF_FETCH;
        end
        if (cmd_wr && cmd[7:5] == tcdp_pkg::OP_MISC && cmd[4] == 1'b0)
        begin
            unique case (n_fld)
                tcdp_pkg::N_SEQ: mm_d[tcdp_pkg::MM_NOSEQ] = cmd[3];
                tcdp_pkg::N_FGATE: mm_d[tcdp_pkg::MM_FGATE] = cmd[3];
                tcdp_pkg::N_BUS: mm_d[tcdp_pkg::MM_BUS16] = cmd[3];
                default: ;
            endcase
        end
        if (mreset)
        begin
            mm_d = tcdp_pkg::REG_RESET;
            pf_st_d = tcdp_pkg::PF_FETCH;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            grp_q <= tcdp_pkg::GP_FIRST;
            elem_q <= tcdp_pkg::EL_MODE;
            byte_q <= 1'b1;
            mm_q <= tcdp_pkg::REG_RESET;
            pf_q <= tcdp_pkg::REG_RESET;
            pf_st_q <= tcdp_pkg::PF_IDLE;
        end
        else
        begin
            grp_q <= grp_d;
            elem_q <= elem_d;
            byte_q <= byte_d;
            mm_q <= mm_d;
            pf_q <= pf_d;
            pf_st_q <= pf_st_d;
        end
    end

    // Status byte sampled every cycle from the group outputs
    always_comb
    begin
        status_d = 8'h00;
        status_d[tcdp_pkg::ST_BYTE] = byte_q;
        status_d[tcdp_pkg::ST_OUT_LSB +: NC] = st_a;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            status_q <= 8'h00;
        else
            status_q <= status_d;
    end

    // Control port always gives status; data port gives the latch
    assign db_out = cd_sel ? {8'h00, status_q} : pf_q;
    assign db_oe_n = ~rd_stb;
    assign cmp_en_v = {3'h0, mm_q[tcdp_pkg::MM_CMP2], mm_q[tcdp_pkg::MM_CMP1]};

    // Five identical groups; only the first two carry an alarm
    for (genvar i = 0; i < NC; i++)
    begin : g_grp
        assign gi[i].wr_mode = wr_mode_v[i];
        assign gi[i].wr_load = wr_load_v[i];
        assign gi[i].wr_hold = wr_hold_v[i];
        assign gi[i].wr_alarm = wr_alarm_v[i];
        assign gi[i].wr_be = be;
        assign gi[i].wr_data = wdata;
        assign gi[i].cmd_arm = arm_v[i];
        assign gi[i].cmd_disarm = disarm_v[i];
        assign gi[i].cmd_load = load_v[i];
        assign gi[i].cmd_save = save_v[i];
        assign gi[i].cmd_step = step_v[i];
        assign gi[i].cmd_set = set_v[i];
        assign gi[i].cmd_clr = clr_v[i];
        assign gi[i].cmd_reset = mreset;
        assign gi[i].cmp_en = cmp_en_v[i];
        assign mode_a[i] = gi[i].mode_q;
        assign load_a[i] = gi[i].load_q;
        assign hold_a[i] = gi[i].hold_q;
        assign alarm_a[i] = gi[i].alarm_q;
        assign st_a[i] = gi[i].status_bit;
        assign out_pin[i] = gi[i].out_pin;
        assign out_oe_n[i] = gi[i].out_oe_n;
        tcdp_group #(
            .HAS_ALARM(i < 2)
        ) u_grp (
            .core_clk(core_clk),
            .nrst(nrst),
            .tick(cnt_tick[i]),
            .gate(gate_in[i]),
            .g(gi[i])
        );
    end
endmodule // tcdp_top
`default_nettype wire

//--- testbench/tcdp_chk_asserts.sv
// Port assertions for the timer data port block
`timescale 1ns/100ps
`default_nettype none
module tcdp_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cd_sel,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic [15:0] db_in,
    input wire logic [15:0] db_out,
    input wire logic db_oe_n,
    input wire logic [4:0] cnt_tick,
    input wire logic [4:0] gate_in,
    input wire logic [4:0] out_pin,
    input wire logic [4:0] out_oe_n
);
    logic [19:0] gh_q, gh_d;
    logic [2:0] idle_q, idle_d;
    logic quiet;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Gate history is deep because a gate may pass a synchroniser first
    always_comb
    begin
        gh_d = {gh_q[14:0], gate_in};
        idle_d = (rd_stb || wr_stb) ? 3'h0 : idle_q + {2'h0, idle_q != 3'h7};
    end
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            {gh_q, idle_q} <= 23'h000000;
        else
            {gh_q, idle_q} <= {gh_d, idle_d};
    assign quiet = cnt_tick == 5'h00 && !wr_stb && gh_q == {4{gate_in}};
    sequence s_ldp;
        cd_sel && wr_stb && db_in[7:5] == 3'h0 && db_in[2:0] != 3'h0 &&
        db_in[2:0] != 3'h6;
    endsequence
    AST_OE: assert property (db_oe_n == !rd_stb)
        else $error("bus enable not tied to read strobe");
    AST_STAT_ZERO: assert property (cd_sel && rd_stb |-> db_out[15:6] == 0)
        else $error("status upper bits not zero");
    // Pins in high impedance may carry an inverted comparator, so skip them
    AST_STAT_OUT: assert property (cd_sel && rd_stb |->
        (db_out[5:1] & ~$past(out_oe_n)) ==
        ($past(out_pin) & ~$past(out_oe_n)))
        else $error("status output bits differ from pins");
    AST_LDP_BYTE: assert property (s_ldp ##1 (!rd_stb && !wr_stb) [*3] ##1 (cd_sel && rd_stb) |-> db_out[0])
        else $error("byte pointer not set after pointer load");
    AST_LATCH_HOLD: assert property (!cd_sel && $past(!cd_sel) && idle_q > 3'h2 |-> $stable(db_out))
        else $error("latch changed without a port access");
    AST_OUT_HOLD: assert property ($past(quiet) |-> $stable(out_pin))
        else $error("output pin moved without a cause");
    AST_OEN_HOLD: assert property ($past(quiet) |-> $stable(out_oe_n))
        else $error("pin enable moved without a write");
    AST_RESET: assert property ($rose(nrst) |-> db_out == 16'h0000 && out_pin == 5'h00)
        else $error("outputs not cleared by reset");
endmodule // tcdp_chk
bind tcdp_top tcdp_chk u_chk (.core_clk(core_clk), .nrst(nrst),
    .cd_sel(cd_sel), .rd_stb(rd_stb), .wr_stb(wr_stb), .db_in(db_in),
    .db_out(db_out), .db_oe_n(db_oe_n), .cnt_tick(cnt_tick),
    .gate_in(gate_in), .out_pin(out_pin), .out_oe_n(out_oe_n));
`default_nettype wire

//--- testbench/tcdp_host.sv
// Host processor model driving the control and data ports
`timescale 1ns/100ps
`default_nettype none
module tcdp_host (
    input wire logic core_clk,
    output logic cd_sel,
    output logic rd_stb,
    output logic wr_stb,
    output logic [15:0] db_in
);
    logic bus16 = 1'b0;
    initial
    begin
        {cd_sel, rd_stb, wr_stb} = 3'h0;
        db_in = 16'h0000;
    end
    // One access, then idle time so the latch can refill
    task automatic acc(input logic c, input logic w, input logic [15:0] d);
        @(posedge core_clk) #1;
        {cd_sel, rd_stb, wr_stb} = {c, !w, w};
        db_in = d;
        @(posedge core_clk) #1;
        {cd_sel, rd_stb, wr_stb} = 3'h0;
        db_in = ~d; // Released bus keeps no stale value
        repeat (2) @(posedge core_clk);
    endtask
    // Prefix byte only on the wide bus
    task automatic cmd(input logic [7:0] c);
        acc(1'b1, 1'b1, {bus16 ? 8'hff : 8'h00, c});
        if (c == 8'hef || c == 8'he7)
            bus16 = c[3];
    endtask
endmodule // tcdp_host
`default_nettype wire

//--- testbench/tcdp_top_bench.sv
// Self-checking bench for the timer data port block
`timescale 1ns/100ps
`default_nettype none
module tcdp_top_bench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cd_sel, rd_stb, wr_stb, db_oe_n;
    logic [15:0] db_in, db_out;
    logic [4:0] cnt_tick = 5'h00, gate_in = 5'h00, out_pin, out_oe_n;
    logic [15:0] val [15];
    logic [15:0] exp_q [$];
    int failures = 0, cmp_count = 0, seed = 32'h6e72;
    tcdp_top u_dut (.core_clk(core_clk), .nrst(nrst), .cd_sel(cd_sel),
        .rd_stb(rd_stb), .wr_stb(wr_stb), .db_in(db_in), .db_out(db_out),
        .db_oe_n(db_oe_n), .cnt_tick(cnt_tick), .gate_in(gate_in),
        .out_pin(out_pin), .out_oe_n(out_oe_n));
    tcdp_host u_host (.core_clk(core_clk), .cd_sel(cd_sel), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .db_in(db_in));
    initial
        forever #10 core_clk = ~core_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Note the expected value, then let the host read
    task automatic rd(input logic c, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.acc(c, 1'b0, 16'h0000);
    endtask
    // Each read result is judged against the oldest note
    // Mid-cycle look keeps clear of the edge that updates status and latch
    always @(negedge core_clk)
        if (rd_stb === 1'b1)
            check(db_out, exp_q.pop_front());
    initial
    begin
        repeat (3000) @(posedge core_clk);
        failures++;
        complete_run();
    end
    initial
    begin
        for (int i = 0; i < 15; i++)
            val[i] = 16'($random(seed));
        val[0] = 16'h0001;
        val[3] = {val[3][15:8], 8'h04};
        val[6] = 16'hc085;
        val[9] = {val[9][15:8], 8'h01};
        val[12] = {val[12][15:8], 8'h00};
        repeat (16) @(posedge core_clk);
        #1 nrst = 1'b1;
        // Random ticks and gates while all counters are disarmed
        repeat (8)
        begin
            @(posedge core_clk) #1;
            cnt_tick = 5'($random(seed));
            gate_in = 5'($random(seed));
        end
        @(posedge core_clk) #1 {cnt_tick, gate_in} = 10'h000;
        repeat (2) @(posedge core_clk);
        check({11'h000, out_pin}, 16'h0000);
        u_host.cmd(8'hef);
        u_host.cmd(8'h01);
        for (int i = 0; i < 15; i++)
            u_host.acc(1'b0, 1'b1, val[i]);
        u_host.cmd(8'h01);
        for (int i = 0; i < 16; i++)
            rd(1'b0, val[i % 15]);
        u_host.cmd(8'h19);
        rd(1'b0, val[2]);
        rd(1'b0, val[5]);
        $display("test register sequencing done");
        u_host.cmd(8'h1f);
        rd(1'b1, 16'h000d);
        rd(1'b0, 16'h000d);
        check({11'h000, out_oe_n}, 16'h0002);
        $display("test status byte done");
        u_host.cmd(8'h07);
        u_host.acc(1'b0, 1'b1, val[1]);
        u_host.acc(1'b0, 1'b1, val[4]);
        u_host.acc(1'b0, 1'b1, 16'h2004);
        u_host.cmd(8'h07);
        rd(1'b0, val[1]);
        rd(1'b0, val[4]);
        rd(1'b0, 16'h2004);
        u_host.cmd(8'h41); // Counter 1 takes its load value
        check({11'h000, out_pin}, 16'h0007);
        u_host.cmd(8'h21);
        @(posedge core_clk) #1 cnt_tick = 5'h01;
        @(posedge core_clk) #1 cnt_tick = 5'h00;
        repeat (2) @(posedge core_clk);
        check({11'h000, out_pin}, 16'h0006);
        // Comparator 2 on a high-impedance pin: pin low, status high
        u_host.cmd(8'h17);
        u_host.acc(1'b0, 1'b1, 16'h200c);
        u_host.cmd(8'h42);
        check({11'h000, out_pin}, 16'h0004);
        rd(1'b1, 16'h000d);
        $display("test comparator done");
        u_host.cmd(8'h44);
        u_host.cmd(8'h13);
        @(posedge core_clk) #1 gate_in = 5'h04;
        repeat (8) @(posedge core_clk);
        rd(1'b0, val[8]);
        u_host.cmd(8'h13);
        rd(1'b0, val[7]);
        $display("test gate save done");
        u_host.cmd(8'he7);
        u_host.cmd(8'h0a);
        rd(1'b0, {8'h00, val[4][7:0]});
        rd(1'b1, 16'h000c);
        rd(1'b0, {8'h00, val[4][15:8]});
        rd(1'b1, 16'h000d);
        $display("test narrow bus done");
        complete_run();
    end
endmodule // tcdp_top_bench
`default_nettype wire
